// >>> cas_defines.svh
// Purpose: constants of the configuration access port with shadow accumulators
// Assumes: 32-bit configuration data, 8-bit word address, one core clock
// Notes: offsets are word addresses on the configuration port
//
// How it works
// (R01) requester never raises read and write together
// (R02) shadow kind only for data wider than bus
// (R03) every write answered write_good or fail
// (R04) every read answered read_good with data, or fail
// (R05) one reply per request, none when unmapped
// (R06) reply latency varies; wait for the reply
// (R07) table request waits while core holds memory
// (R08) requester holds txn_tag at zero
// (R09) requester waits for reply before next request
// (R10) register accesses never stall; tables may block
// (R11) each wide bank has its own accumulator
// (R12) shadow access uses the same address
// (R13) plain wide read loads whole accumulator
// (R14) shadow reads return accumulator slices only
// (R15) shadow writes load; plain write merges, commits
// (R16) core updates during accumulation get overwritten
// (R17) requester reads then writes wide data closely
// (R18) wide entries step by a power of two
// (R19) requester walks wide data in ascending order
// (R20) bridge maps kind to address bit, keeps order
// (R21) debug write input held zero in normal use
// (R22) tick source registers pick debug input use
// (R23) access kind bit: zero plain, one shadow
`ifndef CAS_DEFINES_SVH
`define CAS_DEFINES_SVH

`define CAS_DW         32
`define CAS_AW         8
`define CAS_TAG_W      1
// narrow registers
`define CAS_REG_CTRL   8'h00
`define CAS_REG_STAT   8'h01
`define CAS_REG_CDIV   8'h02
`define CAS_REG_TDIV   8'h03
`define CAS_NARROW_END 8'h04
// 48-bit wide register, two words, step of two
`define CAS_REG_WIDE   8'h04
`define CAS_WIDE_W     48
// 65-bit table, three words used of a stride of four
`define CAS_TBL_BASE   8'h40
`define CAS_TBL_W      65
`define CAS_TBL_STRIDE 4
`define CAS_TBL_UNUSED 2'h3
`define CAS_TBL_DEPTH  8
// field positions and reset values
`define CAS_CTRL_CSEL  0
`define CAS_CTRL_TSEL  1
`define CAS_STAT_PEND  16
`define CAS_CDIV_RST   16'h007c
`define CAS_TDIV_RST   16'h0007
`define CAS_DIV_W      16

`endif

// >>> cas_pkg.sv
// Purpose: types of the configuration access port
// Assumes: cas_defines.svh provides the widths
// Notes: request and reply travel as packed structs
`include "cas_defines.svh"

package cas_pkg;

	// table access sequencer, one-hot
	typedef enum logic [3:0]
	{
		CAS_IDLE = 4'b0001,
		CAS_TRD  = 4'b0010,
		CAS_TRDW = 4'b0100,
		CAS_TWR  = 4'b1000
	} cas_state_t;

	typedef struct packed
	{
		logic                  rd;
		logic                  wr;
		logic                  shadow;
		logic [`CAS_TAG_W-1:0] txn_tag;
		logic [`CAS_AW-1:0]    addr;
		logic [`CAS_DW-1:0]    wdata;
	} cas_req_t;

	typedef struct packed
	{
		logic               write_good;
		logic               read_good;
		logic               fail;
		logic [`CAS_DW-1:0] rdata;
	} cas_rsp_t;

	typedef struct packed
	{
		cas_state_t                     state;
		cas_rsp_t                       rsp;
		logic [`CAS_TBL_W-1:0]          acc_tbl;
		logic [`CAS_WIDE_W-1:0]         acc_wide;
		logic [`CAS_WIDE_W-1:0]         wide;
		logic [`CAS_AW-1:0]             pend_idx;
		logic [1:0]                     pend_word;
		logic [`CAS_DW-1:0]             pend_wdata;
		logic [1:0]                     sel;
		logic [1:0][`CAS_DIV_W-1:0]     div;
		logic [1:0][`CAS_DIV_W-1:0]     cnt;
		logic [1:0]                     tick;
		logic [15:0]                    core_ticks;
		logic [1:0]                     dbg_s1;
		logic [1:0]                     dbg_s2;
		logic [1:0]                     dbg_q;
	} cas_st_t;

endpackage

// >>> cas_tbl_mem.sv
// Purpose: table storage with one write and one registered read port
// Assumes: single clock, read data one cycle after the read enable
// Notes: read data hold until the next read
`timescale 1ns/100ps

module cas_tbl_mem
#(
	parameter int W     = 65,
	parameter int DEPTH = 8,
	parameter int AW    = 3
)
(
	// clock
	input  wire logic          clk,
	// write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	// read port
	input  wire logic          re,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);

	logic [W-1:0] mem [DEPTH];

	// storage and registered read
	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
		if (re)
			rdata <= mem[raddr];
	end

endmodule

// >>> cas_cfg_port.sv
// Purpose: configuration access port with shadow accumulators and tick dividers
// Assumes: requester on core_clk, waits for each reply, txn_tag held low
// Notes: narrow and wide registers answer next cycle; table plain accesses wait for the memory
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
`include "cas_defines.svh"

module cas_cfg_port
	import cas_pkg::*;
#(
	parameter int TBL_DEPTH = `CAS_TBL_DEPTH,
	parameter int IDX_W     = $clog2(`CAS_TBL_DEPTH)
)
(
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// configuration requests and replies
	input  wire cas_req_t             cfg_req,
	output cas_rsp_t                  cfg_rsp,
	// debug write pins
	input  wire logic [1:0]           debug_write_data,
	// core side of the table, has priority
	input  wire logic                 core_tbl_req,
	input  wire logic                 core_tbl_we,
	input  wire logic [IDX_W-1:0]     core_tbl_idx,
	input  wire logic [`CAS_TBL_W-1:0] core_tbl_wdata,
	output logic      [`CAS_TBL_W-1:0] core_tbl_rdata,
	// tick outputs
	output logic                      core_tick,
	output logic                      timing_tick
);

	localparam int PADW = 3 * `CAS_DW;

	localparam cas_st_t ST_RST = '{
		state:   CAS_IDLE,
		rsp:     '0,
		div:     {`CAS_TDIV_RST, `CAS_CDIV_RST},
		default: '0
	};

	cas_st_t                  st_r;
	cas_st_t                  st_nxt;
	logic                     req_v;
	logic                     narrow_hit;
	logic                     wide_hit;
	logic                     tbl_hit;
	logic [`CAS_AW-1:0]       tbl_off;
	logic                     mem_we;
	logic                     mem_re;
	logic                     cfg_wr_go;
	logic                     cfg_rd_go;
	logic [IDX_W-1:0]         mem_waddr;
	logic [IDX_W-1:0]         mem_raddr;
	logic [`CAS_TBL_W-1:0]    mem_wdata;
	logic [`CAS_TBL_W-1:0]    mem_rdata;
	logic [`CAS_TBL_W-1:0]    tbl_merge;
	logic [PADW-1:0]          tbl_pend_pad;
	logic [PADW-1:0]          tbl_req_pad;
	logic [PADW-1:0]          wide_req_pad;

	// one bus-width slice out of a padded wide word
	function automatic logic [`CAS_DW-1:0] slice(input logic [PADW-1:0] d, input logic [1:0] w);
		slice = d[w*`CAS_DW +: `CAS_DW];
	endfunction

	// replace one slice of a padded wide word
	function automatic logic [PADW-1:0] merge(input logic [PADW-1:0] d, input logic [1:0] w,
		input logic [`CAS_DW-1:0] v);
		logic [PADW-1:0] t;
		t = d;
		t[w*`CAS_DW +: `CAS_DW] = v;
		merge = t;
	endfunction

	// address decode; wide entries step by powers of two
	assign req_v      = cfg_req.rd | cfg_req.wr;
	assign narrow_hit = cfg_req.addr < `CAS_NARROW_END;
	assign wide_hit   = cfg_req.addr[`CAS_AW-1:1] == `CAS_REG_WIDE >> 1; // R18
	assign tbl_off    = cfg_req.addr - `CAS_TBL_BASE;
	assign tbl_hit    = (cfg_req.addr >= `CAS_TBL_BASE)
		&& (32'(tbl_off) < TBL_DEPTH * `CAS_TBL_STRIDE)
		&& (cfg_req.addr[1:0] != `CAS_TBL_UNUSED); // R18

	// the requested slice merged into each accumulator
	assign tbl_req_pad  = merge({31'h0, st_r.acc_tbl}, cfg_req.addr[1:0], cfg_req.wdata);
	assign wide_req_pad = merge({48'h0, st_r.acc_wide}, {1'b0, cfg_req.addr[0]}, cfg_req.wdata);

	// table port: the core always wins, the configuration side waits
	assign cfg_wr_go = (st_r.state == CAS_TWR) && !core_tbl_req; // R07 R10
	assign cfg_rd_go = (st_r.state == CAS_TRD) && !core_tbl_req; // R07
	assign tbl_pend_pad = merge({{(PADW-`CAS_TBL_W){1'b0}}, st_r.acc_tbl}, st_r.pend_word, st_r.pend_wdata);
	assign tbl_merge    = tbl_pend_pad[`CAS_TBL_W-1:0]; // R15
	assign mem_we    = core_tbl_req ? core_tbl_we : cfg_wr_go;
	assign mem_re    = core_tbl_req ? !core_tbl_we : cfg_rd_go;
	assign mem_waddr = core_tbl_req ? core_tbl_idx : st_r.pend_idx[IDX_W-1:0];
	assign mem_raddr = mem_waddr;
	assign mem_wdata = core_tbl_req ? core_tbl_wdata : tbl_merge; // R16

	cas_tbl_mem
	#(
		.W     (`CAS_TBL_W),
		.DEPTH (TBL_DEPTH),
		.AW    (IDX_W)
	)
	u_mem
	(
		.clk   (core_clk),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (mem_wdata),
		.re    (mem_re),
		.raddr (mem_raddr),
		.rdata (mem_rdata)
	);

	// next state of the whole block
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rsp = '0;
		// debug pins pass two flops before use
		st_nxt.dbg_s1 = debug_write_data;
		st_nxt.dbg_s2 = st_r.dbg_s1;
		st_nxt.dbg_q  = st_r.dbg_s2;
		// tick dividers: own count or debug edge
		for (int i = 0; i < 2; i++)
		begin
			st_nxt.tick[i] = 1'b0;
			if (st_r.sel[i])
				st_nxt.tick[i] = st_r.dbg_s2[i] & ~st_r.dbg_q[i]; // R22
			else if (st_r.cnt[i] >= st_r.div[i])
			begin
				st_nxt.cnt[i]  = '0;
				st_nxt.tick[i] = 1'b1;
			end
			else
				st_nxt.cnt[i] = st_r.cnt[i] + 16'h0001;
		end
		if (st_r.tick[0])
			st_nxt.core_ticks = st_r.core_ticks + 16'h0001;
		// the core advances the wide timestamp on each timing tick
		if (st_r.tick[1])
			st_nxt.wide = st_r.wide + 48'h000000000001;
		// requests; registers answer next cycle in any state but CAS_TRDW or a CAS_TWR commit
		if (req_v)
		begin
			if (narrow_hit)
			begin
				if (cfg_req.shadow)
					st_nxt.rsp.fail = 1'b1; // R02 R23
				else if (cfg_req.wr)
				begin
					st_nxt.rsp.write_good = 1'b1; // R03
					unique case (cfg_req.addr)
						`CAS_REG_CTRL:
							st_nxt.sel = cfg_req.wdata[`CAS_CTRL_TSEL:`CAS_CTRL_CSEL];
						`CAS_REG_CDIV:
							st_nxt.div[0] = cfg_req.wdata[`CAS_DIV_W-1:0];
						`CAS_REG_TDIV:
							st_nxt.div[1] = cfg_req.wdata[`CAS_DIV_W-1:0];
						default:
						begin
							st_nxt.rsp.write_good = 1'b0;
							st_nxt.rsp.fail       = 1'b1; // R03
						end
					endcase
				end
				else
				begin
					st_nxt.rsp.read_good = 1'b1; // R04
					unique case (cfg_req.addr)
						`CAS_REG_CTRL:
							st_nxt.rsp.rdata = {30'h0, st_r.sel};
						`CAS_REG_STAT:
							st_nxt.rsp.rdata = {15'h0, st_r.state != CAS_IDLE, st_r.core_ticks};
						`CAS_REG_CDIV:
							st_nxt.rsp.rdata = {16'h0, st_r.div[0]};
						default:
							st_nxt.rsp.rdata = {16'h0, st_r.div[1]};
					endcase
				end
			end
			else if (wide_hit)
			begin
				if (cfg_req.rd)
				begin
					st_nxt.rsp.read_good = 1'b1; // R04
					if (cfg_req.shadow)
						st_nxt.rsp.rdata = slice({48'h0, st_r.acc_wide}, {1'b0, cfg_req.addr[0]}); // R14
					else
					begin
						st_nxt.acc_wide  = st_r.wide; // R13 R11
						st_nxt.rsp.rdata = slice({48'h0, st_r.wide}, {1'b0, cfg_req.addr[0]});
					end
				end
				else
				begin
					st_nxt.rsp.write_good = 1'b1; // R03
					st_nxt.acc_wide = wide_req_pad[`CAS_WIDE_W-1:0]; // R15 R12
					if (!cfg_req.shadow)
						st_nxt.wide = st_nxt.acc_wide; // R15 R16
				end
			end
			else if (tbl_hit && st_r.state == CAS_IDLE)
			begin
				if (cfg_req.shadow && cfg_req.rd)
				begin
					st_nxt.rsp.read_good = 1'b1;
					st_nxt.rsp.rdata = slice({31'h0, st_r.acc_tbl}, cfg_req.addr[1:0]); // R14
				end
				else if (cfg_req.shadow)
				begin
					st_nxt.rsp.write_good = 1'b1;
					st_nxt.acc_tbl = tbl_req_pad[`CAS_TBL_W-1:0]; // R15 R12
				end
				else
				begin
					st_nxt.pend_idx   = tbl_off >> 2;
					st_nxt.pend_word  = cfg_req.addr[1:0];
					st_nxt.pend_wdata = cfg_req.wdata;
					st_nxt.state      = cfg_req.wr ? CAS_TWR : CAS_TRD; // R06
				end
			end
			// unmapped or overlapped table requests produce no reply
		end
		// table sequencer; its reply wins over a colliding register reply
		unique case (st_r.state)
			CAS_IDLE:
				;
			CAS_TRD:
				if (cfg_rd_go)
					st_nxt.state = CAS_TRDW; // R07
			CAS_TRDW:
			begin
				st_nxt.acc_tbl = mem_rdata; // R13 R11
				st_nxt.rsp     = '{write_good: 1'b0, read_good: 1'b1, fail: 1'b0,
					rdata: slice({31'h0, mem_rdata}, st_r.pend_word)}; // R04
				st_nxt.state   = CAS_IDLE;
			end
			CAS_TWR:
				if (cfg_wr_go)
				begin
					st_nxt.acc_tbl = tbl_merge;
					st_nxt.rsp     = '{write_good: 1'b1, read_good: 1'b0, fail: 1'b0,
						rdata: '0}; // R03 R15
					st_nxt.state   = CAS_IDLE;
				end
		endcase
	end

	// state register
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			st_r <= ST_RST;
		else
			st_r <= st_nxt;
	end

	assign cfg_rsp        = st_r.rsp;
	assign core_tick      = st_r.tick[0];
	assign timing_tick    = st_r.tick[1];
	assign core_tbl_rdata = mem_rdata;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_tbl_rd_grant;
		st_r.state == CAS_TRD && !core_tbl_req;
	endsequence

	sequence s_read_reply;
		cfg_rsp.read_good && !cfg_rsp.fail && !cfg_rsp.write_good;
	endsequence

	property p_one_reply;
		$onehot0({cfg_rsp.write_good, cfg_rsp.read_good, cfg_rsp.fail});
	endproperty
	a_one_reply: assert property (p_one_reply) else $error("two reply codes at once"); // R05

	property p_unmapped_silent;
		req_v && !narrow_hit && !wide_hit && !tbl_hit && st_r.state == CAS_IDLE
			|=> !cfg_rsp.write_good && !cfg_rsp.read_good && !cfg_rsp.fail;
	endproperty
	a_unmapped_silent: assert property (p_unmapped_silent) else $error("reply to unmapped address"); // R05

	property p_reg_reply;
		req_v && (narrow_hit || wide_hit) && !(st_r.state == CAS_TRDW || cfg_wr_go)
			|=> ($past(cfg_req.wr) ? (cfg_rsp.write_good || cfg_rsp.fail) : (cfg_rsp.read_good || cfg_rsp.fail));
	endproperty
	a_reg_reply: assert property (p_reg_reply) else $error("register access without reply"); // R10

	property p_shadow_narrow_fail;
		req_v && narrow_hit && cfg_req.shadow && !(st_r.state == CAS_TRDW || cfg_wr_go) |=> cfg_rsp.fail;
	endproperty
	a_shadow_narrow_fail: assert property (p_shadow_narrow_fail) else $error("narrow shadow not failed"); // R02

	property p_tbl_wait;
		st_r.state == CAS_TRD && core_tbl_req |=> st_r.state == CAS_TRD && !cfg_rsp.read_good;
	endproperty
	a_tbl_wait: assert property (p_tbl_wait) else $error("table read passed a busy memory"); // R07

	property p_tbl_rd_reply;
		s_tbl_rd_grant |-> mem_re ##2 s_read_reply;
	endproperty
	a_tbl_rd_reply: assert property (p_tbl_rd_reply) else $error("table read reply not two cycles after grant"); // R04

	property p_acc_capture;
		s_tbl_rd_grant ##1 1'b1 |=> st_r.acc_tbl == $past(mem_rdata);
	endproperty
	a_acc_capture: assert property (p_acc_capture) else $error("accumulator missed the plain read"); // R13

	property p_shadow_rd_nomem;
		req_v && cfg_req.rd && cfg_req.shadow && tbl_hit && st_r.state == CAS_IDLE && !core_tbl_req
			|-> !mem_re ##1 s_read_reply;
	endproperty
	a_shadow_rd_nomem: assert property (p_shadow_rd_nomem) else $error("shadow read touched memory"); // R14

	property p_commit;
		cfg_wr_go |-> mem_we && mem_wdata == tbl_merge ##1 cfg_rsp.write_good;
	endproperty
	a_commit: assert property (p_commit) else $error("plain table write not committed"); // R15

	property p_dbg_tick;
		st_r.sel[1] && st_r.dbg_s2[1] && !st_r.dbg_q[1] |=> timing_tick;
	endproperty
	a_dbg_tick: assert property (p_dbg_tick) else $error("debug edge gave no timing tick"); // R22

	property p_rdata_quiet;
		!cfg_rsp.read_good |-> cfg_rsp.rdata == '0;
	endproperty
	a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data without read_good"); // R04

	property p_wide_commit;
		req_v && cfg_req.wr && wide_hit && !cfg_req.shadow |=> st_r.wide == st_r.acc_wide;
	endproperty
	a_wide_commit: assert property (p_wide_commit) else $error("plain wide write not committed"); // R15

	property p_shadow_wr_nomem;
		req_v && cfg_req.wr && cfg_req.shadow && tbl_hit && st_r.state == CAS_IDLE && !core_tbl_req
			|-> !mem_we ##1 cfg_rsp.write_good;
	endproperty
	a_shadow_wr_nomem: assert property (p_shadow_wr_nomem) else $error("shadow write touched memory"); // R15

endmodule

// >>> cas_host_model.sv
// Purpose: requester model standing in for the host bridge on the configuration port
// Assumes: one request at a time, reply awaited under a bound of 60 cycles
// Notes: xfer returns reply kind {write_good, read_good, fail}, read data and cycles waited
`timescale 1ns/100ps

module cas_host_model
	import cas_pkg::*;
(
	// clock
	input  wire logic     core_clk,
	// request and reply
	output cas_req_t      cfg_req,
	input  wire cas_rsp_t cfg_rsp
);
	// idle bus until the first request
	initial cfg_req = '0;

	// one request of one cycle, then wait for its reply before returning
	task automatic xfer(input logic rd, input logic sh, input logic [7:0] a, input logic [31:0] d,
		output logic [2:0] kind, output logic [31:0] q, output int n);
		kind = 3'h0;
		q = 32'h0;
		@(posedge core_clk);
		cfg_req.rd <= rd;
		cfg_req.wr <= !rd;
		cfg_req.shadow <= sh;
		cfg_req.txn_tag <= '0;
		cfg_req.addr <= a;
		cfg_req.wdata <= d;
		@(posedge core_clk);
		cfg_req.rd <= 1'b0;
		cfg_req.wr <= 1'b0;
		cfg_req.wdata <= ~d; // stale data never left on the bus
		for (n = 1; n < 60; n++)
		begin
			#1;
			if (cfg_rsp.write_good || cfg_rsp.read_good || cfg_rsp.fail)
			begin
				kind = {cfg_rsp.write_good, cfg_rsp.read_good, cfg_rsp.fail};
				q = cfg_rsp.rdata;
				break;
			end
			@(posedge core_clk);
		end
	endtask
endmodule

// >>> cas_cfg_port_tb.sv
// Purpose: self-checking bench of the configuration access port
// Assumes: host model issues requests; bench plays the core side of the table
// Notes: reply kinds are {write_good, read_good, fail}
`timescale 1ns/100ps
`include "cas_defines.svh"

module cas_cfg_port_tb
	import cas_pkg::*;
;
	localparam logic [2:0] K_WG = 3'h4;
	localparam logic [2:0] K_RG = 3'h2;
	localparam logic [2:0] K_FL = 3'h1;
	localparam logic [2:0] K_NO = 3'h0;

	logic             core_clk = 1'b0;
	logic             rst_n = 1'b0;
	cas_req_t         cfg_req;
	cas_rsp_t         cfg_rsp;
	logic [1:0]       debug_write_data = 2'h0;
	logic             core_tbl_req = 1'b0;
	logic             core_tbl_we = 1'b0;
	logic [2:0]       core_tbl_idx = 3'h0;
	logic [64:0]      core_tbl_wdata = '0;
	logic [64:0]      core_tbl_rdata;
	logic             core_tick;
	logic             timing_tick;
	int               num_errors = 0;
	int               num_checks = 0;

	// 125 MHz clock
	always #4 core_clk = ~core_clk;

	cas_cfg_port dut_u (.core_clk(core_clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
		.debug_write_data(debug_write_data), .core_tbl_req(core_tbl_req), .core_tbl_we(core_tbl_we),
		.core_tbl_idx(core_tbl_idx), .core_tbl_wdata(core_tbl_wdata), .core_tbl_rdata(core_tbl_rdata),
		.core_tick(core_tick), .timing_tick(timing_tick));

	cas_host_model host_u (.core_clk(core_clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

	// compare and count
	task automatic chk(input logic [64:0] got, input logic [64:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one access with its expected reply
	task automatic acc(input logic rd, input logic sh, input logic [7:0] a, input logic [31:0] d,
		input logic [2:0] ek, input logic [31:0] ed);
		logic [2:0]  k;
		logic [31:0] q;
		int          n;
		host_u.xfer(rd, sh, a, d, k, q, n);
		chk(k, ek);
		if (ek == K_RG)
			chk(q, ed);
	endtask

	// core side owns the table for one cycle
	task automatic core_op(input logic we, input logic [2:0] i, input logic [64:0] w, input logic [64:0] e);
		@(posedge core_clk);
		core_tbl_req <= 1'b1;
		core_tbl_we <= we;
		core_tbl_idx <= i;
		core_tbl_wdata <= w;
		@(posedge core_clk);
		core_tbl_req <= 1'b0;
		#1;
		if (!we)
			chk(core_tbl_rdata, e);
	endtask

	// reset values of the control and divider registers
	task automatic t_reset();
		acc(1, 0, `CAS_REG_CTRL, 0, K_RG, 32'h0);
		acc(1, 0, `CAS_REG_CDIV, 0, K_RG, 32'h7c);
		acc(1, 0, `CAS_REG_TDIV, 0, K_RG, 32'h7);
		$display("test reset done");
	endtask

	// register writes answer write_good and read back
	task automatic t_regs();
		acc(0, 0, `CAS_REG_CDIV, 32'h1234, K_WG, 0);
		acc(0, 0, `CAS_REG_TDIV, 32'h0010, K_WG, 0);
		acc(1, 0, `CAS_REG_CDIV, 0, K_RG, 32'h1234);
		acc(1, 0, `CAS_REG_TDIV, 0, K_RG, 32'h0010);
		$display("test regs done");
	endtask

	// failures and silent unmapped addresses
	task automatic t_refuse();
		logic [7:0] um [4] = '{8'h10, 8'h43, 8'h60, 8'h80};
		acc(0, 0, `CAS_REG_STAT, 32'h1, K_FL, 0);
		acc(1, 1, `CAS_REG_CDIV, 0, K_FL, 0);
		acc(0, 1, `CAS_REG_CTRL, 32'h1, K_FL, 0);
		foreach (um[i])
			acc(um[i][0], 0, um[i], 0, K_NO, 0);
		$display("test refuse done");
	endtask

	// wide table write and read through the accumulator
	task automatic t_wide();
		acc(0, 1, 8'h44, 32'haaaa0001, K_WG, 0);
		acc(0, 1, 8'h45, 32'hbbbb0002, K_WG, 0);
		acc(0, 0, 8'h46, 32'h1, K_WG, 0);
		core_op(0, 1, 0, {1'b1, 32'hbbbb0002, 32'haaaa0001});
		acc(1, 0, 8'h45, 0, K_RG, 32'hbbbb0002);
		core_op(1, 1, {1'b0, 32'h5, 32'h6}, 0);
		acc(1, 1, 8'h44, 0, K_RG, 32'haaaa0001);
		acc(0, 1, `CAS_REG_WIDE, 32'h77, K_WG, 0);
		acc(0, 0, 8'h05, 32'h000000ab, K_WG, 0);
		acc(1, 0, 8'h05, 0, K_RG, 32'h000000ab);
		acc(1, 1, 8'h46, 0, K_RG, 32'h1);
		$display("test wide done");
	endtask

	// core update between read and commit is overwritten
	task automatic t_rmw();
		acc(0, 1, 8'h48, 32'hc0c0c0c0, K_WG, 0);
		acc(0, 1, 8'h49, 32'hd0d0d0d0, K_WG, 0);
		acc(0, 0, 8'h4a, 32'h0, K_WG, 0);
		acc(1, 0, 8'h48, 0, K_RG, 32'hc0c0c0c0);
		core_op(1, 2, {65{1'b1}}, 0);
		acc(0, 0, 8'h49, 32'hf00df00d, K_WG, 0);
		core_op(0, 2, 0, {1'b0, 32'hf00df00d, 32'hc0c0c0c0});
		$display("test rmw done");
	endtask

	// table read waits while the core holds the memory
	task automatic t_stall();
		logic [2:0]  k;
		logic [31:0] q;
		int          n;
		@(posedge core_clk);
		core_tbl_req <= 1'b1;
		core_tbl_we <= 1'b0;
		fork
			host_u.xfer(1, 0, 8'h45, 0, k, q, n);
			begin
				repeat (12) @(posedge core_clk);
				core_tbl_req <= 1'b0;
			end
		join
		chk(k, K_RG);
		chk(q, 32'h5);
		chk(n > 11, 1'b1);
		$display("test stall done");
	endtask

	// debug pin edges drive both ticks when selected
	task automatic t_debug();
		int          nc;
		int          nt;
		logic [2:0]  k;
		logic [31:0] s0;
		int          n;
		nc = 0;
		nt = 0;
		acc(0, 0, `CAS_REG_CTRL, 32'h3, K_WG, 0);
		host_u.xfer(1, 0, `CAS_REG_STAT, 0, k, s0, n);
		chk(k, K_RG);
		repeat (4) @(posedge core_clk);
		for (int i = 0; i < 16; i++)
		begin
			@(posedge core_clk);
			debug_write_data <= (i < 4) ? 2'h3 : 2'h0;
			#1;
			nc += core_tick;
			nt += timing_tick;
		end
		chk(nc, 1);
		chk(nt, 1);
		acc(1, 0, `CAS_REG_STAT, 0, K_RG, s0 + 32'h1);
		acc(0, 0, `CAS_REG_CTRL, 32'h0, K_WG, 0);
		// own dividers: a tick every div+1 cycles
		acc(0, 0, `CAS_REG_CDIV, 32'h3, K_WG, 0);
		acc(0, 0, `CAS_REG_TDIV, 32'h7, K_WG, 0);
		repeat (20) @(posedge core_clk);
		nc = 0;
		nt = 0;
		repeat (16)
		begin
			@(posedge core_clk);
			#1;
			nc += core_tick;
			nt += timing_tick;
		end
		chk(nc, 4);
		chk(nt, 2);
		$display("test debug done");
	endtask

	// counts and verdict
	task automatic end_of_test();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// watchdog, far beyond the expected few hundred cycles
	initial
	begin
		#50000;
		num_errors++;
		end_of_test();
	end

	// main sequence
	initial
	begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_regs();
		t_refuse();
		t_wide();
		t_rmw();
		t_stall();
		t_debug();
		end_of_test();
	end
endmodule
